// ===== tfs_pkg.sv
package tfs_pkg;

  // Command header bytes
  localparam logic [7:0]  CLA_ISO       = 8'h00;
  localparam logic [7:0]  INS_SELECT    = 8'hA4;
  localparam logic [7:0]  INS_READ      = 8'hB0;
  localparam logic [7:0]  P1_BY_NAME    = 8'h04;
  localparam logic [7:0]  P2_FIRST      = 8'h00;
  localparam logic [7:0]  P1_BY_ID      = 8'h00;
  localparam logic [7:0]  P2_NO_FCI     = 8'h0C;
  localparam logic [7:0]  LC_AID        = 8'h07;
  localparam logic [7:0]  LC_FID        = 8'h02;

  // File identifiers
  localparam logic [15:0] FID_CC        = 16'hE103;
  localparam logic [15:0] FID_SYS       = 16'hE101;
  localparam logic [15:0] FID_DATA_BASE = 16'h0001;

  // Read count limits
  localparam logic [7:0]  LE_MIN        = 8'h01;
  localparam logic [7:0]  LE_CAP        = 8'hF6;

  // Status words
  localparam logic [15:0] SW_OK         = 16'h9000;
  localparam logic [15:0] SW_NOT_FOUND  = 16'h6A82;
  localparam logic [15:0] SW_INS_BAD    = 16'h6D00;
  localparam logic [15:0] SW_CLA_BAD    = 16'h6E00;
  localparam logic [15:0] SW_LEN_BAD    = 16'h6700;
  localparam logic [15:0] SW_DENIED     = 16'h6982;
  localparam logic [15:0] SW_P1P2_BAD   = 16'h6A86;

  // Byte positions within a command and whole command lengths
  localparam int POS_CLA      = 0;
  localparam int POS_INS      = 1;
  localparam int POS_P1       = 2;
  localparam int POS_P2       = 3;
  localparam int POS_LC       = 4;
  localparam int POS_DATA     = 5;
  localparam int AID_BYTES    = 7;
  localparam int BUF_BYTES    = 13;
  localparam logic [4:0] LEN_APP_SEL  = 5'h0D;
  localparam logic [4:0] LEN_FILE_SEL = 5'h07;
  localparam logic [4:0] LEN_READ     = 5'h05;

  typedef enum logic [3:0] {
    FILE_NONE = 4'b0001,
    FILE_CC   = 4'b0010,
    FILE_DATA = 4'b0100,
    FILE_SYS  = 4'b1000
  } tfs_file_type;

  typedef enum logic [6:0] {
    ST_COLLECT  = 7'b0000001,
    ST_DECODE   = 7'b0000010,
    ST_READREQ  = 7'b0000100,
    ST_READWAIT = 7'b0001000,
    ST_READOUT  = 7'b0010000,
    ST_SW1      = 7'b0100000,
    ST_SW2      = 7'b1000000
  } tfs_state_type;

endpackage

// ===== tfs_fifo.sv
`timescale 1ns/10ps
module tfs_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;
    logic          space;
  } tfs_fifo_regs_type;

  tfs_fifo_regs_type r_q;
  tfs_fifo_regs_type r_d;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              pop;

  // Space is a flop so the upstream ready is glitch free
  assign inReady  = r_q.space;
  assign outValid = (r_q.count != '0);
  assign outData  = mem[r_q.rdPtr];
  assign push     = inValid && r_q.space;
  assign pop      = outValid && outReady;

  // Pointer and fill bookkeeping
  always_comb
  begin
    r_d = r_q;
    if (push)
      r_d.wrPtr = (r_q.wrPtr == AW'(DEPTH - 1)) ? '0 : r_q.wrPtr + 1'b1;
    if (pop)
      r_d.rdPtr = (r_q.rdPtr == AW'(DEPTH - 1)) ? '0 : r_q.rdPtr + 1'b1;
    r_d.count = r_q.count + CW'(push) - CW'(pop);
    r_d.space = (r_d.count != CW'(DEPTH));
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q       <= '0;
      r_q.space <= 1'b1;
    end
    else
      r_q <= r_d;
  end

  // Storage needs no reset
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[r_q.wrPtr] <= inData;
  end
endmodule

// ===== tfs_read_check.sv
`timescale 1ns/10ps
module tfs_read_check (
  input  wire logic [15:0] offset,
  input  wire logic [7:0]  count,
  input  wire logic [15:0] fileLen,
  output logic             countOk,
  output logic             rangeOk
);
  import tfs_pkg::*;

  logic [16:0] endPos;
  logic [15:0] capLen;

  // Larger of file length and the single command cap
  assign capLen  = (fileLen > {8'h00, LE_CAP}) ? fileLen : {8'h00, LE_CAP};
  assign countOk = (count >= LE_MIN) && ({8'h00, count} <= capLen);
  // Seventeen bits so an offset near the top cannot wrap
  assign endPos  = {1'b0, offset} + {9'h000, count};
  assign rangeOk = (endPos <= {1'b0, fileLen});
endmodule

// ===== tfs_apdu.sv
`timescale 1ns/10ps
// Summary of operation
// - Application select header and seven-byte identifier
// - Application select answers 9000, 6A82 or 6D00
// - Container file select uses identifier E103
// - Container file current only on 9000
// - Data file identifiers 0001 upward
// - Data file current on 9000, else 6A82
// - System file identifier E101, current on 9000
// - Failed system select returns 6A82, no data
// - Read is B0 with offset and count
// - Offset plus count within file length
// - Count from 01 up to max(length, F6)
// - Good read returns bytes then 9000
// - Rejected read returns only its status
// - Bad P1 or P2 answers 6A86
// - Unknown instruction answers 6D00
module tfs_apdu #(
  parameter logic [55:0] APP_ID     = 56'h0102030405060A, // arbitrary
  parameter int          DATA_FILES = 1,
  parameter int          FIFO_DEPTH = 16
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  cmdValid,
  input  wire logic [7:0]            cmdData,
  input  wire logic                  cmdLast,
  output logic                       cmdReady,
  output logic                       rspValid,
  output logic [7:0]                 rspData,
  output logic                       rspLast,
  input  wire logic                  rspReady,
  output logic                       memRdEn,
  output tfs_pkg::tfs_file_type      memFile,
  output logic [15:0]                memAddr,
  input  wire logic [7:0]            memRdData,
  input  wire logic [15:0]           ccLen,
  input  wire logic [15:0]           dataLen,
  input  wire logic [15:0]           sysLen,
  input  wire logic                  dataReadDenied
);
  import tfs_pkg::*;

  typedef struct packed {
    tfs_state_type              state;
    logic [BUF_BYTES-1:0][7:0]  cmdBuf;
    logic [4:0]                 cnt;
    logic                       appSel;
    tfs_file_type               curFile;
    logic [15:0]                addr;
    logic [7:0]                 remain;
    logic [15:0]                sw;
    logic                       rspValid;
    logic [7:0]                 rspData;
    logic                       rspLast;
    logic                       memRdEn;
  } tfs_regs_type;

  tfs_regs_type r_q;
  tfs_regs_type r_d;

  logic         fifoValid;
  logic [8:0]   fifoData;
  logic         fifoReady;
  logic [7:0]   cla;
  logic [7:0]   ins;
  logic [7:0]   p1;
  logic [7:0]   p2;
  logic [7:0]   lc;
  logic [15:0]  fid;
  logic [15:0]  readOff;
  logic [7:0]   readLe;
  logic [55:0]  aidRx;
  logic [15:0]  curLen;
  logic         countOk;
  logic         rangeOk;
  logic         isAppSel;
  logic         isFileSel;
  logic         isRead;
  logic         fidData;
  tfs_file_type selFile;
  logic [15:0]  decSw;
  logic         decAppSel;
  tfs_file_type decFile;
  logic         decRead;

  // Incoming bytes are buffered so the block layer can run ahead
  tfs_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (cmdValid),
    .inData   ({cmdLast, cmdData}),
    .inReady  (cmdReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (fifoReady)
  );

  // Drained only while collecting, so a busy decoder back-pressures
  assign fifoReady = (r_q.state == ST_COLLECT);

  // Command fields
  assign cla     = r_q.cmdBuf[POS_CLA];
  assign ins     = r_q.cmdBuf[POS_INS];
  assign p1      = r_q.cmdBuf[POS_P1];
  assign p2      = r_q.cmdBuf[POS_P2];
  assign lc      = r_q.cmdBuf[POS_LC];
  assign fid     = {r_q.cmdBuf[POS_DATA], r_q.cmdBuf[POS_DATA+1]};
  assign readOff = {p1, p2};
  assign readLe  = r_q.cmdBuf[POS_LC];
  assign aidRx   = {r_q.cmdBuf[POS_DATA],   r_q.cmdBuf[POS_DATA+1],
                    r_q.cmdBuf[POS_DATA+2], r_q.cmdBuf[POS_DATA+3],
                    r_q.cmdBuf[POS_DATA+4], r_q.cmdBuf[POS_DATA+5],
                    r_q.cmdBuf[POS_DATA+6]}; // First byte is the top

  // Length of whichever file is current
  always_comb
  begin
    unique case (r_q.curFile)
      FILE_CC:   curLen = ccLen;
      FILE_DATA: curLen = dataLen;
      FILE_SYS:  curLen = sysLen;
      default:   curLen = '0;
    endcase
  end

  tfs_read_check u_read_check (
    .offset  (readOff),
    .count   (readLe),
    .fileLen (curLen),
    .countOk (countOk),
    .rangeOk (rangeOk)
  );

  assign isAppSel  = (ins == INS_SELECT) && (p1 == P1_BY_NAME)
                   && (p2 == P2_FIRST);
  assign isFileSel = (ins == INS_SELECT) && (p1 == P1_BY_ID)
                   && (p2 == P2_NO_FCI);
  assign isRead    = (ins == INS_READ);
  assign fidData   = (fid >= FID_DATA_BASE)
                   && (fid < FID_DATA_BASE + 16'(DATA_FILES));

  // Which file a select by identifier names
  always_comb
  begin
    if (fid == FID_CC)
      selFile = FILE_CC;
    else if (fid == FID_SYS)
      selFile = FILE_SYS;
    else if (fidData)
      selFile = FILE_DATA;
    else
      selFile = FILE_NONE;
  end

  // Command decode, evaluated once the whole command is held
  always_comb
  begin
    decSw     = SW_INS_BAD;
    decAppSel = r_q.appSel;
    decFile   = r_q.curFile;
    decRead   = 1'b0;
    if (ins == INS_SELECT)
    begin
      if (cla != CLA_ISO)
        decSw = SW_INS_BAD;
      else if (isAppSel)
      begin
        decFile = FILE_NONE;
        if (r_q.cnt == LEN_APP_SEL && lc == LC_AID && aidRx == APP_ID)
        begin
          decSw     = SW_OK;
          decAppSel = 1'b1;
        end
        else
        begin
          decSw     = SW_NOT_FOUND;
          decAppSel = 1'b0;
        end
      end
      else if (isFileSel)
      begin
        // No session application means no file can be found
        if (r_q.cnt == LEN_FILE_SEL && lc == LC_FID && r_q.appSel
            && selFile != FILE_NONE)
        begin
          decSw   = SW_OK;
          decFile = selFile;
        end
        else
        begin
          decSw   = SW_NOT_FOUND;
          decFile = FILE_NONE;
        end
      end
      else
        decSw = SW_P1P2_BAD;
    end
    else if (isRead)
    begin
      if (cla != CLA_ISO)
        decSw = SW_CLA_BAD;
      else if (r_q.curFile == FILE_NONE)
        decSw = SW_NOT_FOUND;
      else if (r_q.cnt != LEN_READ || !countOk || !rangeOk)
        decSw = SW_LEN_BAD;
      else if (r_q.curFile == FILE_DATA && dataReadDenied)
        decSw = SW_DENIED;
      else
      begin
        decSw   = SW_OK;
        decRead = 1'b1;
      end
    end
    else
      decSw = SW_INS_BAD;
  end

  // Main sequencer
  always_comb
  begin
    r_d = r_q;
    unique case (r_q.state)
      ST_COLLECT:
      begin
        if (fifoValid)
        begin
          if (r_q.cnt < 5'(BUF_BYTES))
            r_d.cmdBuf[r_q.cnt] = fifoData[7:0];
          // Saturate so an oversized command still fails its length test
          if (r_q.cnt != '1)
            r_d.cnt = r_q.cnt + 5'h01;
          if (fifoData[8])
            r_d.state = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        r_d.sw      = decSw;
        r_d.appSel  = decAppSel;
        r_d.curFile = decFile;
        r_d.addr    = readOff;
        r_d.remain  = readLe;
        if (decRead)
          r_d.state = ST_READREQ;
        else
        begin
          r_d.state    = ST_SW1;
          r_d.rspValid = 1'b1;
          r_d.rspData  = decSw[15:8];
        end
      end
      ST_READREQ:
        r_d.state = ST_READWAIT;
      ST_READWAIT:
      begin
        r_d.state    = ST_READOUT;
        r_d.rspValid = 1'b1;
        r_d.rspData  = memRdData;
      end
      ST_READOUT:
      begin
        if (rspReady)
        begin
          r_d.addr   = r_q.addr + 16'h0001;
          r_d.remain = r_q.remain - 8'h01;
          if (r_q.remain == 8'h01)
          begin
            r_d.state   = ST_SW1;
            r_d.rspData = r_q.sw[15:8];
          end
          else
          begin
            r_d.state    = ST_READREQ;
            r_d.rspValid = 1'b0;
          end
        end
      end
      ST_SW1:
      begin
        if (rspReady)
        begin
          r_d.state   = ST_SW2;
          r_d.rspData = r_q.sw[7:0];
          r_d.rspLast = 1'b1;
        end
      end
      ST_SW2:
      begin
        if (rspReady)
        begin
          r_d.state    = ST_COLLECT;
          r_d.rspValid = 1'b0;
          r_d.rspLast  = 1'b0;
          r_d.cnt      = '0;
        end
      end
      default:
      begin
        r_d.state    = ST_COLLECT;
        r_d.rspValid = 1'b0;
        r_d.rspLast  = 1'b0;
        r_d.cnt      = '0;
      end
    endcase
    r_d.memRdEn = (r_d.state == ST_READREQ);
  end

  // State register; reset leaves no application or file selected
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      r_q         <= '0;
      r_q.state   <= ST_COLLECT;
      r_q.curFile <= FILE_NONE;
    end
    else
      r_q <= r_d;
  end

  assign rspValid = r_q.rspValid;
  assign rspData  = r_q.rspData;
  assign rspLast  = r_q.rspLast;
  assign memRdEn  = r_q.memRdEn;
  assign memFile  = r_q.curFile;
  assign memAddr  = r_q.addr;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  a_app_select_ok: assert property (
    r_q.state == ST_DECODE && cla == CLA_ISO && isAppSel
    && r_q.cnt == LEN_APP_SEL && lc == LC_AID && aidRx == APP_ID
    |=> r_q.appSel && r_q.sw == SW_OK && r_q.rspData == SW_OK[15:8])
    else $error("application select not completed");
  a_cc_current: assert property (
    r_q.curFile != FILE_CC ##1 r_q.curFile == FILE_CC |-> r_q.sw == SW_OK)
    else $error("container file current without success");
  a_data_current: assert property (
    r_q.curFile != FILE_DATA ##1 r_q.curFile == FILE_DATA
    |-> r_q.sw == SW_OK)
    else $error("data file current without success");
  a_sys_current: assert property (
    $changed(r_q.curFile) && r_q.curFile == FILE_SYS |-> r_q.sw == SW_OK)
    else $error("system file current without success");
  a_fail_clears: assert property (
    r_q.state == ST_DECODE && isFileSel && cla == CLA_ISO
    |=> r_q.sw == SW_OK || (r_q.curFile == FILE_NONE
        && r_q.sw == SW_NOT_FOUND))
    else $error("failed select left a file current");
  a_fail_no_data: assert property (
    r_q.state == ST_DECODE && !decRead
    |=> r_q.state == ST_SW1 ##1 !r_q.memRdEn [*2])
    else $error("rejected command produced data");
  a_read_range: assert property (
    r_q.state == ST_DECODE ##1 r_q.state == ST_READREQ
    |-> $past(rangeOk) && $past(countOk) && r_q.sw == SW_OK)
    else $error("read started outside the file");
  a_status_last: assert property (
    r_q.rspValid && r_q.rspLast
    |-> r_q.state == ST_SW2 && r_q.rspData == r_q.sw[7:0])
    else $error("last byte is not the status trailer");
  a_unknown_ins: assert property (
    r_q.state == ST_DECODE && ins != INS_SELECT && ins != INS_READ
    |=> r_q.sw == SW_INS_BAD && r_q.rspData == SW_INS_BAD[15:8])
    else $error("unknown instruction not answered 6D00");
  a_bad_params: assert property (
    r_q.state == ST_DECODE && cla == CLA_ISO && ins == INS_SELECT
    && !isAppSel && !isFileSel |=> r_q.sw == SW_P1P2_BAD)
    else $error("bad P1 or P2 not answered 6A86");
  a_read_nofile: assert property (
    r_q.state == ST_DECODE && isRead && cla == CLA_ISO
    && r_q.curFile == FILE_NONE |=> r_q.sw == SW_NOT_FOUND)
    else $error("read without file not answered 6A82");

  c_app_select: cover property (
    r_q.state == ST_DECODE ##1 r_q.appSel && r_q.sw == SW_OK);
  c_read_done: cover property (
    r_q.state == ST_READOUT ##[1:20] r_q.state == ST_SW2);
  c_fifo_full: cover property (!cmdReady);
endmodule

// ===== tfs_mem_model.sv
`timescale 1ns/10ps
module tfs_mem_model (
  input  wire logic                  ref_clk,
  input  wire logic                  memRdEn,
  input  wire tfs_pkg::tfs_file_type memFile,
  input  wire logic [15:0]           memAddr,
  output logic      [7:0]            memRdData
);
  import tfs_pkg::*;

  initial memRdData = 8'h3C;

  // Byte is good in the cycle after the strobe; otherwise it flips,
  // so a sample one cycle late cannot match by luck
  always @(posedge ref_clk)
  begin
    if (memRdEn)
      memRdData <= memAddr[7:0] ^ {4'h0, memFile} ^ 8'h5A;
    else
      memRdData <= ~memRdData;
  end
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  import tfs_pkg::*;
  // Arbitrary identifier, not a real one
  localparam logic [55:0] APP = 56'h0A1B2C3D4E5F60;
  logic         ref_clk = 1'b0;
  logic         rst = 1'b1;
  logic         cmdValid = 1'b0;
  logic         cmdLast = 1'b0;
  logic         rspReady = 1'b0;
  logic         dataReadDenied = 1'b0;
  logic         gotDone = 1'b0;
  logic         hold = 1'b0;
  logic [7:0]   cmdData = 8'h00;
  logic [15:0]  ccLen = 16'h000F;
  logic [15:0]  dataLen = 16'h0020;
  logic [15:0]  sysLen = 16'h0012;
  logic         cmdReady, rspValid, rspLast, memRdEn;
  logic [7:0]   rspData, memRdData;
  logic [15:0]  memAddr;
  tfs_file_type memFile;
  logic [7:0]   got[$];
  logic [31:0]  seed = 32'd99964;
  logic [3:0]   cf = 4'h1;
  int           appSel = 0;
  int           errors = 0;
  int           checks = 0;

  always #5 ref_clk = ~ref_clk;

  tfs_apdu #(.APP_ID(APP)) tfs_apdu_i (
    .ref_clk, .rst, .cmdValid, .cmdData, .cmdLast, .cmdReady,
    .rspValid, .rspData, .rspLast, .rspReady, .memRdEn, .memFile,
    .memAddr, .memRdData, .ccLen, .dataLen, .sysLen, .dataReadDenied
  );

  tfs_mem_model tfs_mem_model_i (
    .ref_clk, .memRdEn, .memFile, .memAddr, .memRdData
  );

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Collect response bytes; the consumer stalls at random
  always @(posedge ref_clk)
  begin
    if (rspValid && rspReady)
    begin
      got.push_back(rspData);
      if (rspLast)
        gotDone = 1'b1;
    end
    #1 rspReady = !hold && (rnd() % 4) != 0;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chkN(input int g, input int e);
    checks++;
    if (g != e)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Reference: expected response bytes of one command, file state kept
  task automatic model(input logic [7:0] c[$], output logic [7:0] e[$]);
    logic [15:0] sw, id, p;
    logic [55:0] aid;
    int n, le, of, ln;
    n = c.size();
    e = {};
    id = {c[5], c[6]};
    p = {c[2], c[3]};
    of = p;
    le = c[4];
    aid = '0;
    for (int i = 0; i < 7; i++)
      aid = {aid[47:0], c[5+i]};
    sw = SW_INS_BAD;
    if (c[1] == INS_SELECT && c[0] != CLA_ISO)
      sw = SW_INS_BAD;
    else if (c[1] == INS_SELECT && p == 16'h0400)
    begin
      cf = 4'h1;
      appSel = n == 13 && c[4] == LC_AID && aid == APP && c[12] == 8'h00;
      sw = appSel != 0 ? SW_OK : SW_NOT_FOUND;
    end
    else if (c[1] == INS_SELECT && p == 16'h000C)
    begin
      cf = 4'h1;
      if (appSel != 0 && n == 7 && c[4] == LC_FID)
        cf = id == FID_CC ? 4'h2 : id == FID_SYS ? 4'h8 :
             id == FID_DATA_BASE ? 4'h4 : 4'h1;
      sw = cf != 4'h1 ? SW_OK : SW_NOT_FOUND;
    end
    else if (c[1] == INS_SELECT)
      sw = SW_P1P2_BAD;
    else if (c[1] == INS_READ)
    begin
      ln = cf == 4'h2 ? ccLen : cf == 4'h4 ? dataLen : sysLen;
      if (c[0] != CLA_ISO)
        sw = SW_CLA_BAD;
      else if (cf == 4'h1)
        sw = SW_NOT_FOUND;
      else if (n != 5 || le < 1 || le > (ln > 'hF6 ? ln : 'hF6)
               || of + le > ln)
        sw = SW_LEN_BAD;
      else if (cf == 4'h4 && dataReadDenied)
        sw = SW_DENIED;
      else
      begin
        for (int i = 0; i < le; i++)
          e.push_back(8'(of + i) ^ {4'h0, cf} ^ 8'h5A);
        sw = SW_OK;
      end
    end
    e.push_back(sw[15:8]);
    e.push_back(sw[7:0]);
  endtask

  // Send one command byte by byte, then wait for its whole answer
  task automatic run(input logic [7:0] c[$]);
    logic [7:0] e[$];
    int t;
    model(c, e);
    got = {};
    gotDone = 1'b0;
    for (int i = 0; i < c.size(); i++)
    begin
      cmdData = c[i];
      cmdValid = 1'b1;
      cmdLast = i == c.size() - 1;
      t = 0;
      while (!cmdReady && t < 50) begin @(posedge ref_clk); #1; t++; end
      if (!cmdReady)
      begin
        errors++;
        summarize();
      end
      @(posedge ref_clk);
      #1;
    end
    cmdValid = 1'b0;
    cmdLast = 1'b0;
    t = 0;
    while (!gotDone && t < 4000) begin @(posedge ref_clk); #1; t++; end
    if (!gotDone)
    begin
      errors++;
      summarize();
    end
    chkN(got.size(), e.size());
    foreach (e[i]) if (i < got.size()) chk8(got[i], e[i]);
  endtask

  task automatic selF(input logic [7:0] cl, input logic [15:0] p,
                      input logic [15:0] id);
    run({cl, INS_SELECT, p[15:8], p[7:0], LC_FID, id[15:8], id[7:0]});
  endtask

  task automatic selA(input logic [7:0] cl, input logic [55:0] a);
    run({cl, INS_SELECT, P1_BY_NAME, P2_FIRST, LC_AID, a[55:48],
         a[47:40], a[39:32], a[31:24], a[23:16], a[15:8], a[7:0], 8'h00});
  endtask

  task automatic rd(input logic [7:0] cl, input logic [15:0] of,
                    input logic [7:0] le);
    run({cl, INS_READ, of[15:8], of[7:0], le});
  endtask

  initial
  begin
    int n, t;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    @(posedge ref_clk);
    #1;
    // Stall the consumer; the buffer fills behind the waiting answer
    hold = 1'b1;
    got = {};
    n = 0;
    cmdValid = 1'b1;
    while (cmdReady && n < 24)
    begin
      cmdData = (n % 4 == 1) ? 8'hCA : CLA_ISO;
      cmdLast = (n % 4 == 3);
      @(posedge ref_clk);
      #1;
      n++;
      if (n == 4)
      begin
        cmdValid = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 cmdValid = 1'b1;
      end
    end
    cmdValid = 1'b0;
    cmdLast = 1'b0;
    chkN(n, 20);
    hold = 1'b0;
    t = 0;
    while (got.size() < 10 && t < 300) begin @(posedge ref_clk); #1; t++; end
    if (got.size() < 10)
    begin
      errors++;
      summarize();
    end
    chkN(got.size(), 10);
    foreach (got[k])
      chk8(got[k], k % 2 ? SW_INS_BAD[7:0] : SW_INS_BAD[15:8]);
    chk8({7'h00, cmdReady}, 8'h01);
    // Command sequence, rejections first
    rd(CLA_ISO, 16'h0000, 8'h04);
    selF(CLA_ISO, 16'h000C, FID_CC);
    selA(CLA_ISO, APP ^ 56'h1);
    selA(8'h80, APP);
    selA(CLA_ISO, APP);
    selF(CLA_ISO, 16'h010C, FID_CC);
    run({CLA_ISO, 8'hCA, 8'h00, 8'h00, 8'h00});
    selF(8'h80, 16'h000C, FID_CC);
    selF(CLA_ISO, 16'h000C, FID_CC);
    rd(CLA_ISO, 16'h0000, 8'h0F);
    rd(CLA_ISO, 16'h0001, 8'h0F);
    rd(CLA_ISO, 16'h0000, 8'h00);
    rd(8'h80, 16'h0000, 8'h01);
    selF(CLA_ISO, 16'h000C, FID_DATA_BASE);
    dataReadDenied = 1'b1;
    rd(CLA_ISO, 16'h0002, 8'h04);
    dataReadDenied = 1'b0;
    dataLen = 16'h0100;
    rd(CLA_ISO, 16'h0009, 8'hF7);
    selF(CLA_ISO, 16'h000C, 16'h0002);
    rd(CLA_ISO, 16'h0000, 8'h01);
    selF(CLA_ISO, 16'h000C, FID_SYS);
    rd(CLA_ISO, 16'h0010, 8'h02);
    run({CLA_ISO, INS_SELECT, 8'h00, 8'h0C, 8'h01, 8'hE1});
    rd(CLA_ISO, 16'h0000, 8'h01);
    selF(CLA_ISO, 16'h000C, FID_DATA_BASE);
    rd(CLA_ISO, 16'h0002, 8'h03);
    // Random offsets, counts and lengths around the file end
    for (int k = 0; k < 40; k++)
    begin
      dataLen = 16'(rnd() % 48);
      rd(CLA_ISO, 16'(rnd() % 40), 8'(rnd() % 24));
    end
    summarize();
  end
endmodule
